// ===== core/usb_control_endpoint_responder.sv
// Purpose: token_response_engine for the control_endpoint of a low-speed USB device
// Assumes: link layer delivers decoded tokens and receive results synchronous to clk
// Notes: data endpoint modes and modes 0110/1011 are treated as ignore
// Functional notes
// - A 4-bit mode field, with packet validity, length and toggle, chooses how each token type is answered.
// - Mode 0001 acknowledges a valid SETUP and NAKs every IN and every valid OUT.
// - A checking mode acknowledges an OUT only if it is zero length with toggle one.
// - A checked OUT that fails length or toggle gets STALL, never an acknowledge.
// - A transmit-count mode answers IN with exactly the byte count field's number of bytes.
// - Mode 0000 ignores every token and changes no state.
// - An oversize or invalid SETUP gets no handshake and changes no flag or interrupt.
// - In modes 0001, 0010, 0011 and 1111 a valid SETUP of at most 10 bytes is acknowledged and sets flags, mode 0001, count and interrupt.
// - An oversize or invalid OUT gets no handshake and changes nothing.
// - Mode 0011 stalls every IN and valid OUT without mode change or interrupt.
// - Mode 1111 transmits on IN and on host acknowledge sets flags, mode 0001 and interrupt.
// - Mode 1111 stalls a valid OUT of count other than 2 or toggle zero, sets mode 0011 and interrupts.
// - Mode 1111 acknowledges a valid OUT of count 2 toggle one and records mode 0010, toggle, count 2.
// - Mode 0010 stalls IN, then sets mode 0011 and interrupts.
`timescale 1ns/100ps
`default_nettype none
`include "usb_ep0_params.svh"
module usb_control_endpoint_responder
    import usb_ep0_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tokStrobe,
    input wire token_t tokKind,
    input wire logic [`CNT_W-1:0] rxCount,
    input wire logic rxDataOk,
    input wire logic rxToggle,
    input wire logic rxWrEn,
    input wire logic [`BUF_AW-1:0] rxWrAddr,
    input wire logic [`BYTE_W-1:0] rxWrData,
    input wire logic hostAck,
    input wire logic hostNoAck,
    input wire logic txReady,
    input wire logic fwModeWr,
    input wire logic [`BYTE_W-1:0] fwModeData,
    input wire logic fwCountWr,
    input wire logic [`CNT_W+1:0] fwCountData,
    input wire logic fwBufWr,
    input wire logic [`BUF_AW-1:0] fwBufAddr,
    input wire logic [`BYTE_W-1:0] fwBufData,
    output logic [`BYTE_W-1:0] modeReg,
    output logic [`CNT_W+1:0] countReg,
    output logic [`BYTE_W-1:0] fwBufRdData,
    output logic hsStrobe,
    output hs_t hsCode,
    output logic txValid,
    output logic [`BYTE_W-1:0] txByte,
    output logic txEnd,
    output logic irq,
    output logic busy,
    output logic tokDropped
);
    eng_t eng_r;
    eng_t eng_nxt;
    decision_t dec;

    byte_fifo_if #(.W(`BYTE_W)) txq();

    byte_fifo #(
        .WIDTH(`BYTE_W),
        .DEPTH(`TX_FIFO_DEPTH)
    ) u_txq (
        .clk(clk),
        .rst_n(rst_n),
        .port(txq.store)
    );

    function automatic logic isControlMode(input logic [`MODE_W-1:0] mode);
        return (mode == `MODE_NAK_IO) || (mode == `MODE_STATUS_OUT) ||
               (mode == `MODE_STALL_IO) || (mode == `MODE_ACKIN_STATOUT);
    endfunction

    function automatic logic rxAcceptable(input logic [`CNT_W-1:0] cnt, input logic ok);
        return ok && (cnt <= `MAX_RX_CNT);
    endfunction

    // Pure decode of mode and token into the action and handshake
    function automatic decision_t decide(
        input logic [`MODE_W-1:0] mode,
        input token_t kind,
        input logic [`CNT_W-1:0] cnt,
        input logic ok,
        input logic tog
    );
        decision_t d;
        logic statusGood;
        d.act = ACT_NONE;
        d.hs = HS_ACK;
        statusGood = (cnt == `STATUS_CNT) && (tog == `GOOD_TOGGLE);
        // Disabled, reserved and data-only codes fall out here
        if (!isControlMode(mode)) begin
            return d;
        end
        case (kind)
            TOK_SETUP: begin
                if (rxAcceptable(cnt, ok)) begin
                    d.act = ACT_SETUP;
                end
            end
            TOK_IN: begin
                case (mode)
                    `MODE_NAK_IO: begin
                        d.act = ACT_HS;
                        d.hs = HS_NAK;
                    end
                    `MODE_STALL_IO: begin
                        d.act = ACT_HS;
                        d.hs = HS_STALL;
                    end
                    `MODE_STATUS_OUT: begin
                        d.act = ACT_BAD;
                        d.hs = HS_STALL;
                    end
                    default: begin
                        d.act = ACT_TX;
                    end
                endcase
            end
            TOK_OUT: begin
                if (rxAcceptable(cnt, ok)) begin
                    case (mode)
                        `MODE_NAK_IO: begin
                            d.act = ACT_HS;
                            d.hs = HS_NAK;
                        end
                        `MODE_STALL_IO: begin
                            d.act = ACT_HS;
                            d.hs = HS_STALL;
                        end
                        default: begin
                            d.act = statusGood ? ACT_GOOD : ACT_BAD;
                            d.hs = statusGood ? HS_ACK : HS_STALL;
                        end
                    endcase
                end
            end
            default: begin
                d.act = ACT_NONE;
            end
        endcase
        return d;
    endfunction

    assign dec = decide(eng_r.modeReg.mode, tokKind, rxCount, rxDataOk, rxToggle);

    always_comb begin
        eng_nxt = eng_r;
        eng_nxt.hsStrobe = 1'b0;
        eng_nxt.txEnd = 1'b0;
        eng_nxt.irq = 1'b0;
        eng_nxt.tokDropped = 1'b0;
        txq.wrValid = 1'b0;
        txq.wrData = eng_r.epBuf[eng_r.idx];
        txq.rdReady = 1'b0;

        // Firmware side; engine updates below override these
        eng_nxt.bufRd = eng_r.epBuf[fwBufAddr];
        if (fwBufWr) begin
            eng_nxt.epBuf[fwBufAddr] = fwBufData;
        end
        // Link payload wins a same-address clash with firmware
        if (rxWrEn) begin
            eng_nxt.epBuf[rxWrAddr] = rxWrData;
        end
        if (fwModeWr) begin
            eng_nxt.modeReg = mode_reg_t'(fwModeData);
        end
        if (fwCountWr) begin
            eng_nxt.countReg = count_reg_t'(fwCountData);
        end

        // Output stage refills whenever its slot is free
        if (!eng_r.txValid || txReady) begin
            txq.rdReady = 1'b1;
            eng_nxt.txValid = txq.rdValid;
            if (txq.rdValid) begin
                eng_nxt.txByte = txq.rdData;
            end
        end

        case (eng_r.st)
            ST_IDLE: begin
                if (tokStrobe) begin
                    eng_nxt.act = dec.act;
                    eng_nxt.tokMode = eng_r.modeReg.mode;
                    eng_nxt.rxTog = rxToggle;
                    eng_nxt.rxCnt = rxCount;
                    if (dec.act != ACT_NONE && dec.act != ACT_TX) begin
                        eng_nxt.hsStrobe = 1'b1;
                        eng_nxt.hsCode = dec.hs;
                    end
                    if (dec.act == ACT_TX) begin
                        eng_nxt.st = ST_LOAD;
                        eng_nxt.idx = '0;
                        eng_nxt.left = eng_r.countReg.count;
                    end else if (dec.act != ACT_NONE && dec.act != ACT_HS) begin
                        eng_nxt.st = ST_COMMIT;
                    end
                end
            end
            // Handshake already issued; now the outcome is final
            ST_COMMIT: begin
                eng_nxt.st = ST_IDLE;
                eng_nxt.irq = 1'b1;
                case (eng_r.act)
                    ACT_SETUP: begin
                        eng_nxt.modeReg.setup = 1'b1;
                        eng_nxt.modeReg.acked = 1'b1;
                        eng_nxt.modeReg.mode = `MODE_NAK_IO;
                        eng_nxt.countReg.toggle = eng_r.rxTog;
                        eng_nxt.countReg.dataValid = 1'b1;
                        eng_nxt.countReg.count = eng_r.rxCnt;
                    end
                    ACT_GOOD: begin
                        eng_nxt.modeReg.outDone = 1'b1;
                        eng_nxt.modeReg.acked = 1'b1;
                        if (eng_r.tokMode == `MODE_ACKIN_STATOUT) begin
                            eng_nxt.modeReg.mode = `MODE_STATUS_OUT;
                        end
                        eng_nxt.countReg.toggle = `GOOD_TOGGLE;
                        eng_nxt.countReg.dataValid = 1'b1;
                        eng_nxt.countReg.count = `STATUS_CNT;
                    end
                    default: begin
                        eng_nxt.modeReg.mode = `MODE_STALL_IO;
                    end
                endcase
            end
            ST_LOAD: begin
                if (eng_r.left == '0) begin
                    eng_nxt.st = ST_DRAIN;
                end else begin
                    txq.wrValid = 1'b1;
                    if (txq.wrReady) begin
                        eng_nxt.idx = eng_r.idx + 1'b1;
                        eng_nxt.left = eng_r.left - 1'b1;
                    end
                end
            end
            ST_DRAIN: begin
                // Packet ends once queue and output stage are both empty
                if (!txq.rdValid && !eng_r.txValid) begin
                    eng_nxt.txEnd = 1'b1;
                    eng_nxt.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (hostAck) begin
                    eng_nxt.st = ST_IDLE;
                    eng_nxt.irq = 1'b1;
                    eng_nxt.modeReg.inDone = 1'b1;
                    eng_nxt.modeReg.acked = 1'b1;
                    eng_nxt.modeReg.mode = `MODE_NAK_IO;
                end else if (hostNoAck) begin
                    eng_nxt.st = ST_IDLE;
                end
            end
            default: begin
                eng_nxt.st = ST_IDLE;
            end
        endcase

        // Tokens during a transaction are not answered; flag for the link
        if (tokStrobe && eng_r.st != ST_IDLE) begin
            eng_nxt.tokDropped = 1'b1;
        end
        // Kept in a flop so busy carries no decode glitch
        eng_nxt.busy = (eng_nxt.st != ST_IDLE);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eng_r <= '0;
        end else begin
            eng_r <= eng_nxt;
        end
    end

    assign modeReg = eng_r.modeReg;
    assign countReg = eng_r.countReg;
    assign fwBufRdData = eng_r.bufRd;
    assign hsStrobe = eng_r.hsStrobe;
    assign hsCode = eng_r.hsCode;
    assign txValid = eng_r.txValid;
    assign txByte = eng_r.txByte;
    assign txEnd = eng_r.txEnd;
    assign irq = eng_r.irq;
    assign busy = eng_r.busy;
    assign tokDropped = eng_r.tokDropped;
endmodule
`default_nettype wire

// ===== core/usb_ep0_params.svh
// Purpose: constants of the control endpoint token responder
// Assumes: included by bare name from package and modules
// Notes: definitions only
`ifndef USB_EP0_PARAMS_SVH
`define USB_EP0_PARAMS_SVH

`define BYTE_W 8
`define BUF_AW 3
`define CNT_W 4
`define MODE_W 4
`define TX_FIFO_DEPTH 4

`define MODE_DISABLE 4'h0
`define MODE_NAK_IO 4'h1
`define MODE_STATUS_OUT 4'h2
`define MODE_STALL_IO 4'h3
`define MODE_ACKIN_STATOUT 4'hF

// Received counts include the two checksum bytes
`define MAX_RX_CNT 4'hA
`define STATUS_CNT 4'h2
`define GOOD_TOGGLE 1'b1

`endif

// ===== core/usb_ep0_pkg.sv
// Purpose: types shared by the control endpoint token responder
// Assumes: usb_ep0_params.svh holds the numbers
// Notes: engine state is one packed struct
`default_nettype none
`include "usb_ep0_params.svh"
package usb_ep0_pkg;
    typedef enum logic [1:0] {TOK_SETUP, TOK_IN, TOK_OUT, TOK_OTHER} token_t;
    typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} hs_t;
    typedef enum logic [2:0] {ACT_NONE, ACT_HS, ACT_SETUP, ACT_TX, ACT_GOOD, ACT_BAD} act_t;
    typedef enum logic [2:0] {ST_IDLE, ST_COMMIT, ST_LOAD, ST_DRAIN, ST_WAIT} state_t;
    typedef struct packed {
        logic setup;
        logic inDone;
        logic outDone;
        logic acked;
        logic [`MODE_W-1:0] mode;
    } mode_reg_t;
    typedef struct packed {
        logic toggle;
        logic dataValid;
        logic [`CNT_W-1:0] count;
    } count_reg_t;
    typedef struct packed {
        act_t act;
        hs_t hs;
    } decision_t;
    typedef struct packed {
        state_t st;
        act_t act;
        logic [`MODE_W-1:0] tokMode;
        logic rxTog;
        logic [`CNT_W-1:0] rxCnt;
        logic [`CNT_W-1:0] left;
        logic [`BUF_AW-1:0] idx;
        mode_reg_t modeReg;
        count_reg_t countReg;
        logic [(1<<`BUF_AW)-1:0][`BYTE_W-1:0] epBuf;
        logic [`BYTE_W-1:0] bufRd;
        logic hsStrobe;
        hs_t hsCode;
        logic txValid;
        logic [`BYTE_W-1:0] txByte;
        logic txEnd;
        logic irq;
        logic tokDropped;
        logic busy;
    } eng_t;
endpackage
`default_nettype wire

// ===== core/byte_fifo_if.sv
// Purpose: carrier between the engine and its transmit queue
// Assumes: one filler and one drainer, same clock
// Notes: valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
interface byte_fifo_if #(parameter int W = 8);
    logic wrValid;
    logic wrReady;
    logic [W-1:0] wrData;
    logic rdValid;
    logic rdReady;
    logic [W-1:0] rdData;
    modport user(output wrValid, output wrData, output rdReady, input wrReady, input rdValid, input rdData);
    modport store(input wrValid, input wrData, input rdReady, output wrReady, output rdValid, output rdData);
endinterface
`default_nettype wire

// ===== core/byte_fifo.sv
// Purpose: small synchronous FIFO for outgoing packet bytes
// Assumes: single clock, async active-low reset
// Notes: full and empty come from an occupancy count
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    byte_fifo_if.store port
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } fifo_t;

    fifo_t q_r;
    fifo_t q_nxt;
    logic push;
    logic pop;

    // Pointers wrap at DEPTH, so any depth works
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign port.wrReady = (q_r.cnt != CW'(DEPTH));
    assign port.rdValid = (q_r.cnt != '0);
    assign port.rdData = q_r.mem[q_r.rp];
    assign push = port.wrValid && port.wrReady;
    assign pop = port.rdValid && port.rdReady;

    always_comb begin
        q_nxt = q_r;
        if (push) begin
            q_nxt.mem[q_r.wp] = port.wrData;
            q_nxt.wp = bump(q_r.wp);
        end
        if (pop) begin
            q_nxt.rp = bump(q_r.rp);
        end
        case ({push, pop})
            2'b10: q_nxt.cnt = q_r.cnt + 1'b1;
            2'b01: q_nxt.cnt = q_r.cnt - 1'b1;
            default: q_nxt.cnt = q_r.cnt;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== sim/usb_ep0_monitor.sv
// Purpose: port-level checks of the control endpoint responder
// Assumes: a token counts only when taken with busy low
// Notes: bound to the top module
`timescale 1ns/100ps
`default_nettype none
`include "usb_ep0_params.svh"
module usb_ep0_monitor
    import usb_ep0_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tokStrobe,
    input wire token_t tokKind,
    input wire logic [`CNT_W-1:0] rxCount,
    input wire logic rxDataOk,
    input wire logic rxToggle,
    input wire logic hostAck,
    input wire logic [`BYTE_W-1:0] modeReg,
    input wire logic [`CNT_W+1:0] countReg,
    input wire logic hsStrobe,
    input wire hs_t hsCode,
    input wire logic irq,
    input wire logic busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic take, good, inT, outT;
    logic [3:0] md;
    assign take = tokStrobe && !busy;
    assign good = rxDataOk && rxCount <= `MAX_RX_CNT;
    assign inT = take && tokKind == TOK_IN;
    assign outT = take && tokKind == TOK_OUT && good;
    assign md = modeReg[3:0];
    property p_off; take && md == 4'h0 |=> !hsStrobe ##1 !irq; endproperty
    a_off: assert property (p_off) else $error("disabled mode answered");
    property p_nak; (inT || outT) && md == 4'h1 |=> hsStrobe && hsCode == HS_NAK ##1 !irq; endproperty
    a_nak: assert property (p_nak) else $error("nak missing");
    property p_setup; take && tokKind == TOK_SETUP && good && md inside {4'h1, 4'h2, 4'h3, 4'hF}
        |=> hsStrobe && hsCode == HS_ACK ##1 irq && md == 4'h1 && modeReg[7] && modeReg[4] && countReg[4];
    endproperty
    a_setup: assert property (p_setup) else $error("setup not taken");
    property p_junk; take && tokKind != TOK_IN && !good
        |=> !hsStrobe ##1 !irq && $stable(modeReg) && $stable(countReg); endproperty
    a_junk: assert property (p_junk) else $error("bad packet answered");
    property p_stall; (inT || outT) && md == 4'h3 |=> hsStrobe && hsCode == HS_STALL ##1 !irq && $stable(md);
    endproperty
    a_stall: assert property (p_stall) else $error("stall mode wrong");
    property p_good; outT && md inside {4'h2, 4'hF} && rxCount == `STATUS_CNT && rxToggle
        |=> hsStrobe && hsCode == HS_ACK ##1 irq && modeReg[5] && md == 4'h2 && countReg == 6'h32; endproperty
    a_good: assert property (p_good) else $error("good status wrong");
    property p_to3; (outT && md == 4'hF && (rxCount != `STATUS_CNT || !rxToggle)) || (inT && md == 4'h2)
        |=> hsStrobe && hsCode == HS_STALL ##1 irq && md == 4'h3; endproperty
    a_to3: assert property (p_to3) else $error("bad status wrong");
    property p_inack; busy && hostAck && md == 4'hF |=> irq && md == 4'h1 && modeReg[6]; endproperty
    a_inack: assert property (p_inack) else $error("in ack wrong");
    property p_irq; irq |-> $past(hsStrobe) || $past(hostAck); endproperty
    a_irq: assert property (p_irq) else $error("early irq");
endmodule
bind usb_control_endpoint_responder usb_ep0_monitor mon_u (.clk(clk), .rst_n(rst_n), .tokStrobe(tokStrobe),
    .tokKind(tokKind), .rxCount(rxCount), .rxDataOk(rxDataOk), .rxToggle(rxToggle), .hostAck(hostAck),
    .modeReg(modeReg), .countReg(countReg), .hsStrobe(hsStrobe), .hsCode(hsCode), .irq(irq), .busy(busy));
`default_nettype wire

// ===== sim/usb_host_model.sv
// Purpose: host side answering IN data packets
// Assumes: bench picks ack or silence per packet
// Notes: slow gives ready one cycle in four so the queue fills
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic txEnd,
    input wire logic slow,
    input wire logic ackOn,
    output logic txReady,
    output logic hostAck,
    output logic hostNoAck
);
    logic [1:0] phase_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= 2'h0;
            txReady <= 1'b0;
            hostAck <= 1'b0;
            hostNoAck <= 1'b0;
        end else begin
            phase_r <= phase_r + 2'h1;
            txReady <= !slow || phase_r == 2'h3;
            // Answer only once the packet is over
            hostAck <= txEnd && ackOn;
            hostNoAck <= txEnd && !ackOn;
        end
    end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Purpose: self-checking bench for the control endpoint responder
// Assumes: firmware and link side driven here, host by its model
// Notes: directed table, then seeded random tokens
`timescale 1ns/100ps
`default_nettype none
`include "usb_ep0_params.svh"
module tb_top
    import usb_ep0_pkg::*;
    ;
    logic clk = 1'b0, rst_n = 1'b0, tokStrobe = 1'b0, rxDataOk = 1'b0, rxToggle = 1'b0, rxWrEn = 1'b0;
    logic fwModeWr = 1'b0, fwCountWr = 1'b0, fwBufWr = 1'b0, slow = 1'b0, ackOn = 1'b0;
    token_t tokKind = TOK_SETUP;
    logic [3:0] rxCount = 4'h0;
    logic [2:0] rxWrAddr = 3'h0, fwBufAddr = 3'h0;
    logic [7:0] rxWrData = 8'h00, fwModeData = 8'h00, fwBufData = 8'h00, modeReg, fwBufRdData, txByte;
    logic [5:0] fwCountData = 6'h00, countReg;
    logic hsStrobe, txValid, txEnd, irq, busy, tokDropped, txReady, hostAck, hostNoAck;
    hs_t hsCode;
    logic [7:0] mBuf [8];
    logic [7:0] rxq [$];
    int badCount = 0, testsRun = 0, txEnds = 0;
    localparam logic [19:0] dirTab [28] = '{20'h10A08, 20'h10B08, 20'h30200, 20'h11000, 20'h12208,
        20'h31000, 20'h32A08, 20'h32B08, 20'h32204, 20'hF220C, 20'hF2208, 20'hF230C, 20'hF2A0C, 20'h21000,
        20'h2220C, 20'hF1002, 20'hF1091, 20'hF10F3, 20'hF2F0C, 20'h0020C, 20'h01000, 20'h5020C, 20'h7220C,
        20'hA1000, 20'h4020C, 20'hE220C, 20'hF320C, 20'h1020C};
    localparam logic [3:0] modeList [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hF, 4'h5, 4'h7, 4'hA, 4'h4, 4'hE};
    localparam logic [3:0] cntList [3] = '{4'h2, 4'hA, 4'hB};
    usb_control_endpoint_responder dut_u (.clk(clk), .rst_n(rst_n), .tokStrobe(tokStrobe), .tokKind(tokKind),
        .rxCount(rxCount), .rxDataOk(rxDataOk), .rxToggle(rxToggle), .rxWrEn(rxWrEn), .rxWrAddr(rxWrAddr),
        .rxWrData(rxWrData), .hostAck(hostAck), .hostNoAck(hostNoAck), .txReady(txReady), .fwModeWr(fwModeWr),
        .fwModeData(fwModeData), .fwCountWr(fwCountWr), .fwCountData(fwCountData), .fwBufWr(fwBufWr),
        .fwBufAddr(fwBufAddr), .fwBufData(fwBufData), .modeReg(modeReg), .countReg(countReg),
        .fwBufRdData(fwBufRdData), .hsStrobe(hsStrobe), .hsCode(hsCode), .txValid(txValid), .txByte(txByte),
        .txEnd(txEnd), .irq(irq), .busy(busy), .tokDropped(tokDropped));
    usb_host_model host_u (.clk(clk), .rst_n(rst_n), .txEnd(txEnd), .slow(slow), .ackOn(ackOn),
        .txReady(txReady), .hostAck(hostAck), .hostNoAck(hostNoAck));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) if (txValid === 1'b1 && txReady === 1'b1) rxq.push_back(txByte);
    always @(posedge clk) if (txEnd === 1'b1) txEnds++;
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            badCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic endOfTest;
        if (badCount == 0 && testsRun > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // f holds {data ok, toggle, host acks, host slow}
    task automatic step(input logic [7:0] m, input logic [5:0] n, input logic [1:0] k, input logic [3:0] c,
        input logic [3:0] f);
        logic good;
        logic eIrq;
        logic [7:0] eReg;
        logic [5:0] eCnt;
        int hs;
        int i;
        @(posedge clk);
        fwModeWr <= 1'b1;
        fwModeData <= m;
        fwCountWr <= 1'b1;
        fwCountData <= n;
        ackOn <= f[1];
        slow <= f[0];
        @(posedge clk);
        fwModeWr <= 1'b0;
        fwCountWr <= 1'b0;
        tokStrobe <= 1'b1;
        tokKind <= token_t'(k);
        rxCount <= c;
        rxDataOk <= f[3];
        rxToggle <= f[2];
        rxq.delete();
        txEnds = 0;
        good = f[3] && c <= `MAX_RX_CNT;
        hs = -1;
        eReg = m;
        eCnt = n;
        eIrq = 1'b0;
        if (!(m[3:0] inside {4'h1, 4'h2, 4'h3, 4'hF}) || k == 2'h3 || (k != 2'h1 && !good))
            hs = -1;
        else if (k == 2'h0) begin
            hs = HS_ACK;
            eReg = {m[7:4] | 4'h9, 4'h1};
            eCnt = {f[2], 1'b1, c};
            eIrq = 1'b1;
        end else if (m[3:0] == 4'h1)
            hs = HS_NAK;
        else if (m[3:0] == 4'h3)
            hs = HS_STALL;
        else if (k == 2'h2 && c == `STATUS_CNT && f[2]) begin
            hs = HS_ACK;
            eReg = {m[7:4] | 4'h3, 4'h2};
            eCnt = 6'h32;
            eIrq = 1'b1;
        end else if (k == 2'h2 || m[3:0] == 4'h2) begin
            hs = HS_STALL;
            eReg[3:0] = 4'h3;
            eIrq = 1'b1;
        end
        @(posedge clk);
        tokStrobe <= 1'b0;
        #1;
        chk("handshake", hsStrobe, hs >= 0);
        if (hs >= 0) chk("code", hsCode, hs[7:0]);
        if (hs < 0 && k == 2'h1 && m[3:0] == 4'hF) begin
            for (i = 0; i < 200 && busy === 1'b1; i++) begin
                @(posedge clk);
                #1;
            end
            if (i == 200) begin
                badCount++;
                endOfTest();
            end
            chk("length", 8'(rxq.size()), {4'h0, n[3:0]});
            chk("end pulses", 8'(txEnds), 8'h01);
            for (i = 0; i < rxq.size(); i++) chk("byte", rxq[i], mBuf[i % 8]);
            if (f[1]) begin
                eReg = {m[7:4] | 4'h5, 4'h1};
                eIrq = 1'b1;
            end
        end else begin
            @(posedge clk);
            #1;
        end
        chk("irq", irq, eIrq);
        chk("mode", modeReg, eReg);
        chk("count", countReg, eCnt);
    endtask
    initial begin
        logic [7:0] d;
        logic [3:0] mm, c, f;
        logic [1:0] k;
        int i;
        void'($urandom(73553));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("mode reset", modeReg, 8'h00);
        chk("count reset", countReg, 8'h00);
        for (i = 0; i < 8; i++) begin
            d = 8'($urandom);
            mBuf[i] = d;
            @(posedge clk);
            fwBufWr <= !i[0];
            rxWrEn <= i[0];
            fwBufAddr <= i[2:0];
            rxWrAddr <= i[2:0];
            fwBufData <= d;
            rxWrData <= d;
            @(posedge clk);
            fwBufWr <= 1'b0;
            rxWrEn <= 1'b0;
            @(posedge clk);
            #1;
            chk("buffer", fwBufRdData, d);
        end
        // Reserved codes are driven on purpose to see them ignored
        foreach (dirTab[i]) step({4'h0, dirTab[i][19:16]}, {2'h0, dirTab[i][7:4]}, dirTab[i][13:12],
            dirTab[i][11:8], dirTab[i][3:0]);
        // Second strobe lands while the setup commit is still busy
        @(posedge clk);
        tokStrobe <= 1'b1;
        repeat (2) @(posedge clk);
        tokStrobe <= 1'b0;
        #1;
        chk("dropped", tokDropped, 8'h01);
        for (i = 0; i < 300; i++) begin
            d = 8'($urandom);
            mm = modeList[$urandom % 10];
            k = 2'($urandom);
            c = ($urandom % 2) ? 4'($urandom) : cntList[$urandom % 3];
            f = {($urandom % 4) != 0, 1'($urandom), 1'($urandom), 1'($urandom)};
            if (mm == 4'h2 && k == 2'h2 && f[3] && c <= `MAX_RX_CNT) begin
                c = `STATUS_CNT;
                f[2] = 1'b1;
            end
            step({d[7:4], mm}, 6'($urandom), k, c, f);
        end
        endOfTest();
    end
endmodule
`default_nettype wire
